// [ptc_timers.sv]
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module ptc_timers
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // register bus
  input  wire ptc_axi_req_s axiReq,
  output      ptc_axi_rsp_s axiRsp,
  // pins
  input  wire logic         sharedExtClockPin,
  input  wire logic         timerCExtClockPin,
  input  wire logic         cap1InputPin,
  input  wire logic         cap2InputPin,
  // interrupt
  output      logic         irqRequest
);

  ptc_state_s       st_q;
  ptc_state_s       st_d;
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] fall;
  logic [PIN_N-1:0] rise;
  logic             half;
  logic             instr;
  logic             shExt;
  logic             tcExt;
  logic             aTick;
  logic             bTick;
  logic             cTick;
  logic             wrEn;
  logic             rdEn;
  logic [5:0]       wrIdx;
  logic [5:0]       rdIdx;
  logic             ev1;
  logic             ev2;
  logic             c2Done;
  logic [7:0]       fSet;

  assign pins  = {cap2InputPin, cap1InputPin, timerCExtClockPin, sharedExtClockPin};
  assign half  = st_q.phase[0];
  assign instr = (st_q.phase == PH_LAST);
  assign fall  = {PIN_N{half}} & st_q.samp & ~st_q.sync2;
  assign rise  = {PIN_N{half}} & ~st_q.samp & st_q.sync2;
  // a pending edge is spent on the next instruction cycle, so the lag depends on the phase the edge arrives in
  assign shExt = instr & (st_q.pend[0] | fall[PIN_SH]);
  assign tcExt = instr & (st_q.pend[1] | fall[PIN_TC]);
  assign aTick = st_q.src[SB_TACS] ? shExt : instr;
  assign bTick = st_q.src[SB_TBCS] ? shExt : instr;
  assign cTick = st_q.src[SB_TCCS] ? tcExt : instr;
  assign wrEn  = st_q.awHave & st_q.wHave & ~st_q.rsp.bvalid;
  assign wrIdx = st_q.awAddr[7:2];
  assign rdEn  = axiReq.arvalid & st_q.rsp.arready;
  assign rdIdx = axiReq.araddr[7:2];
  assign ev1 = st_q.run[RB_CAPSEL] & (st_q.src[SB_C1ED] ? rise[PIN_C1] : fall[PIN_C1]);
  assign c2Done = rdEn & st_q.cap2Full
                & ((rdIdx == IDX_CAP2_LO) | (rdIdx == IDX_CAP2_HI))
                & ((rdIdx == IDX_CAP2_LO) | st_q.rdLo)
                & ((rdIdx == IDX_CAP2_HI) | st_q.rdHi);

  always_comb begin
    case (st_q.src[SB_C2ED +: 2])
      ED_FALL:   ev2 = fall[PIN_C2];
      ED_RISE:   ev2 = rise[PIN_C2];
      ED_RISE4:  ev2 = rise[PIN_C2] & (st_q.psc[1:0] == PSC_LAST4[1:0]);
      ED_RISE16: ev2 = rise[PIN_C2] & (st_q.psc == PSC_LAST16);
      default:   ev2 = 1'b0;
    endcase
  end

  function automatic logic wrHit(input logic [5:0] idx);
    return wrEn && st_q.wLane && (wrIdx == idx);
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    case (idx)
      IDX_TA_CNT, IDX_TB_CNT, IDX_PER_A, IDX_PER_B, IDX_FLAGS, IDX_ENABLES,
      IDX_SRC_CFG, IDX_RUN_STAT, IDX_TC_LO, IDX_TC_HI, IDX_CAP1_LO,
      IDX_CAP1_HI, IDX_CAP2_LO, IDX_CAP2_HI, IDX_IRQ_CTRL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] rdByte(input logic [5:0] idx);
    case (idx)
      IDX_TA_CNT:   return st_q.ta;
      IDX_TB_CNT:   return st_q.tb;
      IDX_PER_A:    return st_q.pa;
      IDX_PER_B:    return st_q.pb;
      IDX_FLAGS:    return st_q.flags;
      IDX_ENABLES:  return st_q.ien;
      IDX_SRC_CFG:  return st_q.src;
      IDX_RUN_STAT: return st_q.run;
      IDX_TC_LO:    return st_q.tc[7:0];
      IDX_TC_HI:    return st_q.tc[15:8];
      IDX_CAP1_LO:  return st_q.cap1[7:0];
      IDX_CAP1_HI:  return st_q.cap1[15:8];
      IDX_CAP2_LO:  return st_q.cap2[7:0];
      IDX_CAP2_HI:  return st_q.cap2[15:8];
      IDX_IRQ_CTRL: return {6'h00, st_q.ctl};
      default:      return 8'h00;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    fSet = 8'h00;
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    st_d.phase = st_q.phase + 2'h1;
    if (half) begin
      st_d.samp = st_q.sync2;
    end
    st_d.pend = instr ? 2'h0 : (st_q.pend | {fall[PIN_TC], fall[PIN_SH]});

    if (st_q.src[SB_CHAIN]) begin
      if (st_q.run[RB_TARUN] && aTick) begin
        if (st_q.run[RB_TBRUN]) begin
          if ({st_q.tb, st_q.ta} == {st_q.pb, st_q.pa}) begin
            {st_d.tb, st_d.ta} = 16'h0000;
            fSet[FB_TA] = 1'b1;
          end else begin
            {st_d.tb, st_d.ta} = {st_q.tb, st_q.ta} + 16'h0001;
          end
        end else if (st_q.ta == st_q.pa) begin
          st_d.ta = 8'h00;
          fSet[FB_TA] = 1'b1;
        end else begin
          st_d.ta = st_q.ta + 8'h01;
        end
      end
    end else begin
      if (st_q.run[RB_TARUN] && aTick) begin
        if (st_q.ta == st_q.pa) begin
          st_d.ta = 8'h00;
          fSet[FB_TA] = 1'b1;
        end else begin
          st_d.ta = st_q.ta + 8'h01;
        end
      end
      if (st_q.run[RB_TBRUN] && bTick) begin
        if (st_q.tb == st_q.pb) begin
          st_d.tb = 8'h00;
          fSet[FB_TB] = 1'b1;
        end else begin
          st_d.tb = st_q.tb + 8'h01;
        end
      end
    end

    if (st_q.run[RB_TCRUN] && cTick) begin
      if (!st_q.run[RB_CAPSEL]) begin
        if (st_q.tc == st_q.cap1) begin
          st_d.tc = 16'h0000;
          fSet[FB_TC] = 1'b1;
        end else begin
          st_d.tc = st_q.tc + 16'h0001;
        end
      end else begin
        st_d.tc = st_q.tc + 16'h0001;
        fSet[FB_TC] = (st_q.tc == 16'hFFFF);
      end
    end

    if (ev1) begin
      st_d.cap1 = st_q.tc;
      fSet[FB_C1] = 1'b1;
    end

    if (rise[PIN_C2]) begin
      st_d.psc = st_q.psc + 4'h1;
    end

    if (c2Done) begin
      st_d.run[RB_C2OVF] = st_q.mOvf;
      st_d.mOvf = 1'b0;
      st_d.cap2Full = 1'b0;
      st_d.rdLo = 1'b0;
      st_d.rdHi = 1'b0;
    end else if (rdEn && st_q.cap2Full) begin
      st_d.rdLo = st_q.rdLo | (rdIdx == IDX_CAP2_LO);
      st_d.rdHi = st_q.rdHi | (rdIdx == IDX_CAP2_HI);
    end

    if (ev2) begin
      if (st_d.cap2Full) begin
        st_d.mOvf = 1'b1;
      end else begin
        st_d.cap2 = st_q.tc;
        st_d.cap2Full = 1'b1;
        fSet[FB_C2] = 1'b1;
      end
    end

    // software writes win over counting, so a loaded value is never skipped; only flags set in the same cycle survive a flags write
    if (wrHit(IDX_TA_CNT)) st_d.ta = st_q.wByte;
    if (wrHit(IDX_TB_CNT)) st_d.tb = st_q.wByte;
    if (wrHit(IDX_PER_A)) st_d.pa = st_q.wByte;
    if (wrHit(IDX_PER_B)) st_d.pb = st_q.wByte;
    if (wrHit(IDX_ENABLES)) st_d.ien = st_q.wByte;
    if (wrHit(IDX_SRC_CFG)) st_d.src = st_q.wByte;
    if (wrHit(IDX_RUN_STAT)) st_d.run = (st_d.run & ~RUN_WMASK) | (st_q.wByte & RUN_WMASK);
    if (wrHit(IDX_TC_LO)) st_d.tc[7:0] = st_q.wByte;
    if (wrHit(IDX_TC_HI)) st_d.tc[15:8] = st_q.wByte;
    if (wrHit(IDX_CAP1_LO)) st_d.cap1[7:0] = st_q.wByte;
    if (wrHit(IDX_CAP1_HI)) st_d.cap1[15:8] = st_q.wByte;
    if (wrHit(IDX_IRQ_CTRL)) st_d.ctl = st_q.wByte[1:0];
    st_d.flags = (wrHit(IDX_FLAGS) ? st_q.wByte : st_q.flags) | fSet;
    st_d.irq = st_q.ctl[CB_PERIPHERAL_IRQ_ENABLE] & ~st_q.ctl[CB_GDIS] & |(st_q.flags & st_q.ien & FLAG_MASK);

    if (axiReq.awvalid && st_q.rsp.awready) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_q.rsp.wready) begin
      st_d.wHave = 1'b1;
      st_d.wByte = axiReq.wdata[7:0];
      st_d.wLane = axiReq.wstrb[0];
    end
    if (st_q.rsp.bvalid && axiReq.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (wrEn) begin
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = mapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    st_d.rsp.awready = ~st_d.awHave & ~st_d.rsp.bvalid;
    st_d.rsp.wready = ~st_d.wHave & ~st_d.rsp.bvalid;

    if (rdEn) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rdata = {24'h000000, rdByte(rdIdx)};
      st_d.rsp.rresp = mapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rsp.rvalid && axiReq.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end
    st_d.rsp.arready = ~st_d.rsp.rvalid;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign axiRsp = st_q.rsp;
  assign irqRequest = st_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // writes are excluded: a software load legally overrides any count or flag
  logic wrAny;
  assign wrAny = wrEn & st_q.wLane;

  sequence chainAtPeriod;
    st_q.src[SB_CHAIN] && st_q.run[RB_TARUN] && st_q.run[RB_TBRUN] && aTick && !wrAny
      && ({st_q.tb, st_q.ta} == {st_q.pb, st_q.pa});
  endsequence
  sequence chainCleared;
    ({st_q.tb, st_q.ta} == 16'h0000) && st_q.flags[FB_TA];
  endsequence

  a_chain_wrap: assert property (chainAtPeriod |=> chainCleared)
    else $error("chained timer did not wrap to zero with flag");

  a_tb_wrap: assert property (!st_q.src[SB_CHAIN] && st_q.run[RB_TBRUN] && bTick && !wrAny
      && st_q.tb == st_q.pb |=> st_q.tb == 8'h00 && st_q.flags[FB_TB])
    else $error("timer_b did not wrap at period");

  a_stop_hold: assert property (!st_q.run[RB_TARUN] && !wrAny |=> $stable(st_q.ta))
    else $error("stopped timer_a changed");

  a_cap1_quiet: assert property (!st_q.run[RB_CAPSEL] && !wrAny |=> !$rose(st_q.flags[FB_C1]))
    else $error("cap1 flag set in period mode");

  a_cap2_protect: assert property (ev2 && st_q.cap2Full && !c2Done
      |=> $stable(st_q.cap2) && st_q.mOvf)
    else $error("held capture overwritten or no overflow");

  a_ovf_copy: assert property (c2Done && !ev2 |=> st_q.run[RB_C2OVF] == $past(st_q.mOvf)
      && !st_q.mOvf && !st_q.cap2Full)
    else $error("overflow not transferred after both reads");

  sequence shFallSeen;
    !st_q.src[SB_CHAIN] && st_q.src[SB_TACS] && st_q.run[RB_TARUN] && st_q.pa != 8'h00
      && !wrAny && $fell(st_q.sync2[PIN_SH]);
  endsequence

  a_ext_delay: assert property (shFallSeen |-> ##[1:5] $changed(st_q.ta))
    else $error("external falling edge not counted in time");

  a_irq_gate: assert property (st_q.irq |-> $past(st_q.ctl[CB_PERIPHERAL_IRQ_ENABLE]) && !$past(st_q.ctl[CB_GDIS]))
    else $error("interrupt raised while gated off");

  a_tc_period: assert property (!st_q.run[RB_CAPSEL] && st_q.run[RB_TCRUN] && cTick && !wrAny
      && st_q.tc == st_q.cap1 |=> st_q.tc == 16'h0000 && st_q.flags[FB_TC])
    else $error("timer_c did not wrap at period");

  a_ta_wrap: assert property (!st_q.src[SB_CHAIN] && st_q.run[RB_TARUN] && aTick && !wrAny
      && st_q.ta == st_q.pa |=> st_q.ta == 8'h00 && st_q.flags[FB_TA])
    else $error("timer_a did not wrap at period");

  a_chain_low: assert property (st_q.src[SB_CHAIN] && !st_q.run[RB_TBRUN] && !wrAny
      |=> $stable(st_q.tb))
    else $error("upper byte moved with timer_b stopped");

  a_tc_wrap: assert property (st_q.run[RB_CAPSEL] && st_q.run[RB_TCRUN] && cTick && !wrAny
      && st_q.tc == 16'hFFFF |=> st_q.tc == 16'h0000 && st_q.flags[FB_TC])
    else $error("timer_c free run wrap lost its flag");

  a_cap1_take: assert property (ev1 && !wrAny |=> st_q.cap1 == $past(st_q.tc) && st_q.flags[FB_C1])
    else $error("dual mode capture1 missed");

  a_flag_hold: assert property (st_q.flags[FB_TC] && !wrAny |=> st_q.flags[FB_TC])
    else $error("timer_c flag dropped without software");

  // the prescaler keeps its phase across selection changes, so a stray step would skew captures
  a_psc_hold: assert property (!rise[PIN_C2] |=> $stable(st_q.psc))
    else $error("capture prescaler moved without an edge");

  a_cap2_take: assert property (ev2 && !st_q.cap2Full |=> st_q.cap2Full && st_q.flags[FB_C2])
    else $error("capture2 event not latched");

endmodule // ptc_timers

// [ptc_pkg.sv]
package ptc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_TA_CNT   = 6'h10;
  localparam logic [5:0] IDX_TB_CNT   = 6'h11;
  localparam logic [5:0] IDX_PER_A    = 6'h14;
  localparam logic [5:0] IDX_PER_B    = 6'h15;
  localparam logic [5:0] IDX_FLAGS    = 6'h16;
  localparam logic [5:0] IDX_ENABLES  = 6'h17;
  localparam logic [5:0] IDX_SRC_CFG  = 6'h18;
  localparam logic [5:0] IDX_RUN_STAT = 6'h19;
  localparam logic [5:0] IDX_TC_LO    = 6'h1A;
  localparam logic [5:0] IDX_TC_HI    = 6'h1B;
  localparam logic [5:0] IDX_CAP1_LO  = 6'h1C;
  localparam logic [5:0] IDX_CAP1_HI  = 6'h1D;
  localparam logic [5:0] IDX_CAP2_LO  = 6'h1E;
  localparam logic [5:0] IDX_CAP2_HI  = 6'h1F;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h20;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h02;

  // flag and enable bit positions
  localparam int FB_TC = 6;
  localparam int FB_TB = 5;
  localparam int FB_TA = 4;
  localparam int FB_C2 = 3;
  localparam int FB_C1 = 2;
  localparam logic [7:0] FLAG_MASK = 8'h7C;

  // source configuration bit positions
  localparam int SB_C2ED  = 6;
  localparam int SB_C1ED  = 4;
  localparam int SB_CHAIN = 3;
  localparam int SB_TCCS  = 2;
  localparam int SB_TBCS  = 1;
  localparam int SB_TACS  = 0;

  // run and status bit positions
  localparam int RB_C2OVF  = 7;
  localparam int RB_CAPSEL = 3;
  localparam int RB_TCRUN  = 2;
  localparam int RB_TBRUN  = 1;
  localparam int RB_TARUN  = 0;
  localparam logic [7:0] RUN_WMASK = 8'h3F;

  // interrupt control bit positions
  localparam int CB_PERIPHERAL_IRQ_ENABLE = 0;
  localparam int CB_GDIS = 1;

  // pin slots
  localparam int PIN_SH = 0;
  localparam int PIN_TC = 1;
  localparam int PIN_C1 = 2;
  localparam int PIN_C2 = 3;
  localparam int PIN_N  = 4;

  // instruction cycle is four clocks; pins are sampled on odd phases
  localparam logic [1:0] PH_LAST = 2'h3;

  // capture edge selections
  localparam logic [1:0] ED_FALL   = 2'h0;
  localparam logic [1:0] ED_RISE   = 2'h1;
  localparam logic [1:0] ED_RISE4  = 2'h2;
  localparam logic [1:0] ED_RISE16 = 2'h3;
  localparam logic [3:0] PSC_LAST4  = 4'h3;
  localparam logic [3:0] PSC_LAST16 = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ptc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ptc_axi_rsp_s;

  typedef struct packed {
    ptc_axi_rsp_s rsp;
    logic         awHave;
    logic         wHave;
    logic [7:0]   awAddr;
    logic [7:0]   wByte;
    logic         wLane;
    logic [1:0]   phase;
    logic [3:0]   sync1;
    logic [3:0]   sync2;
    logic [3:0]   samp;
    logic [1:0]   pend;
    logic [7:0]   ta;
    logic [7:0]   tb;
    logic [7:0]   pa;
    logic [7:0]   pb;
    logic [7:0]   flags;
    logic [7:0]   ien;
    logic [7:0]   src;
    logic [7:0]   run;
    logic [1:0]   ctl;
    logic [15:0]  tc;
    logic [15:0]  cap1;
    logic [15:0]  cap2;
    logic         cap2Full;
    logic         rdLo;
    logic         rdHi;
    logic         mOvf;
    logic [3:0]   psc;
    logic         irq;
  } ptc_state_s;

  // pin stages start at the idle-high level, so reset never shows a false edge;
  // a pin held low through reset is then seen as one falling edge
  localparam ptc_state_s ST_RST = '{flags: FLAGS_RST, sync1: '1, sync2: '1, samp: '1, default: '0};

endpackage

// [ptc_pin_model.sv]
`timescale 1ns/1ps
module ptc_pin_model
  import ptc_pkg::*;
(
  // clock
  input  wire logic             clk,
  // one pulse request per pin slot
  input  wire logic [PIN_N-1:0] go,
  // pin levels, idle high
  output      logic [PIN_N-1:0] pins
);
  logic [4:0] cnt [PIN_N] = '{default: 5'h00};

  always @(posedge clk) begin
    for (int k = 0; k < PIN_N; k++) begin
      if (go[k] && cnt[k] == 5'h00) begin
        cnt[k] <= 5'h10;
      end else if (cnt[k] != 5'h00) begin
        cnt[k] <= cnt[k] - 5'h01;
      end
    end
  end

  // low half first, so each pulse is one falling then one rising edge
  always_comb begin
    for (int k = 0; k < PIN_N; k++) begin
      pins[k] = !(cnt[k] > 5'h08);
    end
  end
endmodule // ptc_pin_model

// [tb.sv]
`timescale 1ns/1ps
module tb
  import ptc_pkg::*;
;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wv;
    logic [7:0] ev;
  } ptc_row_s;

  logic             clk         = 1'b0;
  logic             rst_b       = 1'b0;
  ptc_axi_req_s     req         = '0;
  ptc_axi_rsp_s     rsp;
  logic [PIN_N-1:0] go          = '0;
  logic [PIN_N-1:0] pins;
  logic             irq;
  int               failures    = 0;
  int               check_count = 0;
  logic [7:0]       d;
  logic [7:0]       a;
  logic [1:0]       r;
  // read-only bits of run/status and the capture2 pair ignore writes
  ptc_row_s         rows [8]    = '{'{IDX_PER_A, 8'hA5, 8'hA5}, '{IDX_PER_B, 8'h5A, 8'h5A},
                                    '{IDX_ENABLES, 8'h7C, 8'h7C}, '{IDX_SRC_CFG, 8'hF0, 8'hF0},
                                    '{IDX_RUN_STAT, 8'hF0, 8'h30}, '{IDX_CAP1_LO, 8'h34, 8'h34},
                                    '{IDX_CAP2_LO, 8'h77, 8'h00}, '{IDX_IRQ_CTRL, 8'h02, 8'h02}};
  logic [1:0]       edges [4]   = '{ED_FALL, ED_RISE, ED_RISE4, ED_RISE16};
  int               npulse [4]  = '{1, 1, 4, 16};

  always #20 clk = ~clk;

  ptc_timers ptc_timers_inst (
    .clk              (clk),
    .rst_b            (rst_b),
    .axiReq           (req),
    .axiRsp           (rsp),
    .sharedExtClockPin(pins[PIN_SH]),
    .timerCExtClockPin(pins[PIN_TC]),
    .cap1InputPin     (pins[PIN_C1]),
    .cap2InputPin     (pins[PIN_C2]),
    .irqRequest       (irq)
  );

  ptc_pin_model ptc_pin_model_inst (
    .clk (clk),
    .go  (go),
    .pins(pins)
  );

  task automatic print_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    int n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {i, 2'h0};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, v};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [5:0] i);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {i, 2'h0};
    req.rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    d = rsp.rdata[7:0];
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      go[k] <= 1'b1;
      @(posedge clk);
      go[k] <= 1'b0;
      repeat (18) @(posedge clk);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_FLAGS);
    chk(FLAGS_RST, d);
    rd(IDX_RUN_STAT);
    chk(8'h00, d);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].idx, rows[i].wv);
      rd(rows[i].idx);
      chk(rows[i].ev, d);
    end
    wr(6'h3F, 8'hFF);
    chk({6'h00, RESP_SLVERR}, {6'h00, r});
    rd(6'h3F);
    chk({6'h00, RESP_SLVERR}, {6'h00, r});
    wr(IDX_SRC_CFG, 8'h00);
    wr(IDX_ENABLES, 8'h00);
    wr(IDX_IRQ_CTRL, 8'h00);
    // timer_a alone, internal clock, then stopped
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_PER_A, 8'h02);
    wr(IDX_RUN_STAT, 8'h01);
    repeat (40) @(posedge clk);
    wr(IDX_RUN_STAT, 8'h00);
    rd(IDX_FLAGS);
    chk(8'h10, d);
    rd(IDX_TA_CNT);
    a = d;
    chk(8'h01, {7'h00, a <= 8'h02});
    repeat (20) @(posedge clk);
    rd(IDX_TA_CNT);
    chk(a, d);
    // timer_b counting shared pin edges, wraps 3 -> 0
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_SRC_CFG, 8'h02);
    wr(IDX_PER_B, 8'h03);
    wr(IDX_TB_CNT, 8'h00);
    wr(IDX_RUN_STAT, 8'h02);
    pulse(PIN_SH, 5);
    rd(IDX_TB_CNT);
    chk(8'h01, d);
    rd(IDX_FLAGS);
    chk(8'h20, d);
    // chained pair: carry into the high byte, then wrap at 0x0100
    wr(IDX_RUN_STAT, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_SRC_CFG, 8'h09);
    wr(IDX_TA_CNT, 8'hFF);
    wr(IDX_TB_CNT, 8'h00);
    wr(IDX_PER_A, 8'h00);
    wr(IDX_PER_B, 8'h01);
    wr(IDX_RUN_STAT, 8'h03);
    pulse(PIN_SH, 1);
    rd(IDX_TA_CNT);
    chk(8'h00, d);
    rd(IDX_TB_CNT);
    chk(8'h01, d);
    pulse(PIN_SH, 1);
    rd(IDX_TB_CNT);
    chk(8'h00, d);
    rd(IDX_FLAGS);
    chk(8'h10, d);
    wr(IDX_PER_A, 8'h05);
    wr(IDX_RUN_STAT, 8'h01);
    pulse(PIN_SH, 1);
    rd(IDX_TA_CNT);
    chk(8'h01, d);
    rd(IDX_TB_CNT);
    chk(8'h00, d);
    // unchained timer_a on the shared pin
    wr(IDX_SRC_CFG, 8'h01);
    pulse(PIN_SH, 1);
    rd(IDX_TA_CNT);
    chk(8'h02, d);
    // timer_c on its own pin, period pair 0x0002
    wr(IDX_RUN_STAT, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_SRC_CFG, 8'h04);
    wr(IDX_CAP1_LO, 8'h02);
    wr(IDX_CAP1_HI, 8'h00);
    wr(IDX_TC_LO, 8'h00);
    wr(IDX_TC_HI, 8'h00);
    wr(IDX_RUN_STAT, 8'h04);
    pulse(PIN_TC, 3);
    pulse(PIN_C1, 1);
    rd(IDX_TC_LO);
    chk(8'h00, d);
    rd(IDX_FLAGS);
    chk(8'h40, d);
    pulse(PIN_TC, 1);
    rd(IDX_TC_LO);
    chk(8'h01, d);
    rd(IDX_FLAGS);
    chk(8'h40, d);
    // dual mode: timer_c free-runs through its wrap, capture1 takes its value
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_TC_LO, 8'hFF);
    wr(IDX_TC_HI, 8'hFF);
    wr(IDX_RUN_STAT, 8'h0C);
    pulse(PIN_TC, 2);
    pulse(PIN_C1, 1);
    rd(IDX_CAP1_LO);
    chk(8'h01, d);
    rd(IDX_FLAGS);
    chk(8'h44, d);
    // every capture edge code; reading both bytes frees the slot
    wr(IDX_SRC_CFG, 8'h00);
    for (int m = 0; m < 4; m++) begin
      rd(IDX_CAP2_LO);
      rd(IDX_CAP2_HI);
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_SRC_CFG, {edges[m], 6'h00});
      pulse(PIN_C2, npulse[m]);
      rd(IDX_FLAGS);
      chk(8'h08, d & 8'h08);
    end
    // held word survives a second event; overflow shows after both bytes
    rd(IDX_CAP2_LO);
    rd(IDX_CAP2_HI);
    wr(IDX_SRC_CFG, {ED_RISE, 6'h00});
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_ENABLES, 8'h08);
    wr(IDX_IRQ_CTRL, 8'h01);
    pulse(PIN_C2, 1);
    chk(8'h01, {7'h00, irq});
    rd(IDX_CAP2_LO);
    a = d;
    pulse(PIN_C2, 1);
    rd(IDX_CAP2_LO);
    chk(a, d);
    rd(IDX_CAP2_HI);
    rd(IDX_RUN_STAT);
    chk(8'h80, d & 8'h80);
    wr(IDX_IRQ_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    chk(8'h00, {7'h00, irq});
    // second reset in mid-run
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_FLAGS);
    chk(FLAGS_RST, d);
    rd(IDX_TC_LO);
    chk(8'h00, d);
    // prescaler restarts from zero only after reset: the fourth rise captures
    wr(IDX_SRC_CFG, {ED_RISE4, 6'h00});
    pulse(PIN_C2, 3);
    rd(IDX_FLAGS);
    chk(8'h00, d & 8'h08);
    pulse(PIN_C2, 1);
    rd(IDX_FLAGS);
    chk(8'h08, d & 8'h08);
    print_verdict();
  end
endmodule // tb
